/* logic/pia_ctrl.sv */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module pia_ctrl
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [11:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic irq,
	output logic mdc,
	output logic mdio_o,
	output logic mdio_oe_n,
	input wire logic mdio_i
);
	pia_pkg::pia_ctrl_t ctrl;
	logic [15:0] data_wr;
	logic [15:0] data_rd;
	logic busy;
	logic start;
	logic done;
	logic [15:0] frame_rd_data;
	logic [pia_pkg::EV_W-1:0] irq_status;
	logic [pia_pkg::EV_W-1:0] irq_mask;
	logic [pia_pkg::EV_W-1:0] ev_set;
	logic ctrl_wr;
	logic data_wr_hit;
	pia_pkg::pia_req_t req;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	assign ctrl_wr = wr && hit(addr, pia_pkg::OFF_CTRL);
	assign data_wr_hit = wr && hit(addr, pia_pkg::OFF_DATA);
	assign ev_set[pia_pkg::EV_DONE] = done;
	assign ev_set[pia_pkg::EV_REFUSED] = ctrl_wr && busy;

	// ==========================================
	// Access control fields
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			ctrl.phy_addr <= pia_pkg::FIELD5_RESET;
			ctrl.reg_index <= pia_pkg::FIELD5_RESET;
			ctrl.write_not_read <= 1'b0;
		end
		else if (ctrl_wr && !busy)
		begin
			ctrl.phy_addr <= wdata[pia_pkg::PHY_HI:pia_pkg::PHY_LO];
			ctrl.reg_index <= wdata[pia_pkg::IDX_HI:pia_pkg::IDX_LO];
			ctrl.write_not_read <= wdata[pia_pkg::WNR_BIT];
		end
	end

	// ==========================================
	// Busy flag and frame launch
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			busy <= 1'b0;
			start <= 1'b0;
		end
		else
		begin
			start <= ctrl_wr && !busy;
			if (ctrl_wr && !busy)
				busy <= 1'b1;
			else if (done)
				busy <= 1'b0;
		end
	end

	// ==========================================
	// Data register, written and returned halves
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			data_wr <= pia_pkg::DATA_RESET;
		else if (data_wr_hit)
			data_wr <= wdata[pia_pkg::DATA_HI:pia_pkg::DATA_LO];
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			data_rd <= pia_pkg::DATA_RESET;
		else if (done && !ctrl.write_not_read)
			data_rd <= frame_rd_data;
	end

	// Frame data frozen at launch so late data writes cannot tear a frame
	assign req.ctrl = ctrl;
	assign req.wr_data = data_wr;

	// ==========================================
	// Interrupt status and mask
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			irq_status <= pia_pkg::EV_RESET;
		else if (wr && hit(addr, pia_pkg::OFF_IRQ_STATUS))
			irq_status <= (irq_status & ~wdata[pia_pkg::EV_W-1:0]) | ev_set;
		else
			irq_status <= irq_status | ev_set;
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			irq_mask <= pia_pkg::EV_RESET;
		else if (wr && hit(addr, pia_pkg::OFF_IRQ_MASK))
			irq_mask <= wdata[pia_pkg::EV_W-1:0];
	end

	assign irq = |(irq_status & irq_mask);

	// ==========================================
	// Read port, data one cycle after the strobe
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			rdata <= '0;
		else if (rd)
		begin
			rdata <= '0;
			if (hit(addr, pia_pkg::OFF_CTRL))
			begin
				rdata[pia_pkg::PHY_HI:pia_pkg::PHY_LO] <= ctrl.phy_addr;
				rdata[pia_pkg::IDX_HI:pia_pkg::IDX_LO] <= ctrl.reg_index;
				rdata[pia_pkg::WNR_BIT] <= ctrl.write_not_read;
				rdata[pia_pkg::BUSY_BIT] <= busy;
			end
			else if (hit(addr, pia_pkg::OFF_DATA))
				rdata[pia_pkg::DATA_HI:pia_pkg::DATA_LO] <=
					ctrl.write_not_read ? data_wr : data_rd;
			else if (hit(addr, pia_pkg::OFF_IRQ_STATUS))
				rdata[pia_pkg::EV_W-1:0] <= irq_status;
			else if (hit(addr, pia_pkg::OFF_IRQ_MASK))
				rdata[pia_pkg::EV_W-1:0] <= irq_mask;
		end
		else
			rdata <= '0;
	end

	// ==========================================
	// Frame engine on the PHY management pins only
	pia_frame u_frame
	(
		.mclk(mclk),
		.reset(reset),
		.start(start),
		.req(req),
		.done(done),
		.rd_data(frame_rd_data),
		.mdc(mdc),
		.mdio_o(mdio_o),
		.mdio_oe_n(mdio_oe_n),
		.mdio_i(mdio_i)
	);

	// ==========================================
	// Checks
	int unsigned frames_open;

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			frames_open <= 0;
		else if (start && !done)
			frames_open <= frames_open + 1;
		else if (done && !start)
			frames_open <= frames_open - 1;
	end

	a_write_starts: assert property (@(posedge mclk) disable iff (reset)
		ctrl_wr && !busy |=> start && busy ##1 !start)
		else $error("control write did not launch exactly one access");

	a_phy_field: assert property (@(posedge mclk) disable iff (reset)
		ctrl_wr && !busy |=> ctrl.phy_addr == $past(wdata[15:11]))
		else $error("phy select not captured from bits 15:11");

	a_index_field: assert property (@(posedge mclk) disable iff (reset)
		ctrl_wr && !busy |=> ctrl.reg_index == $past(wdata[10:6]))
		else $error("register index not captured from bits 10:6");

	a_wnr_field: assert property (@(posedge mclk) disable iff (reset)
		ctrl_wr && !busy |=> ctrl.write_not_read == $past(wdata[pia_pkg::WNR_BIT]))
		else $error("direction flag not captured from bit 1");

	a_write_drives: assert property (@(posedge mclk) disable iff (reset)
		busy && ctrl.write_not_read && !start && !done |-> !mdio_oe_n)
		else $error("write access released the data pin");

	a_busy_holds: assert property (@(posedge mclk) disable iff (reset)
		busy && !done |=> busy)
		else $error("busy dropped before the frame ended");

	a_busy_clears: assert property (@(posedge mclk) disable iff (reset)
		done |-> busy ##1 !busy)
		else $error("busy not cleared on completion");

	a_busy_from_write: assert property (@(posedge mclk) disable iff (reset)
		$rose(busy) |-> $past(ctrl_wr && !busy))
		else $error("busy set without an accepted control write");

	a_busy_readback: assert property (@(posedge mclk) disable iff (reset)
		rd && hit(addr, pia_pkg::OFF_CTRL) |=> rdata[pia_pkg::BUSY_BIT] == $past(busy))
		else $error("busy flag not visible in bit 0");

	a_ctrl_refused: assert property (@(posedge mclk) disable iff (reset)
		ctrl_wr && busy && !done |=> busy && $stable(ctrl))
		else $error("control write while busy changed the access");

	a_refused_flag: assert property (@(posedge mclk) disable iff (reset)
		ctrl_wr && busy |=> irq_status[pia_pkg::EV_REFUSED])
		else $error("refused control write not flagged");

	a_done_flag: assert property (@(posedge mclk) disable iff (reset)
		done |=> irq_status[pia_pkg::EV_DONE])
		else $error("finished access not flagged");

	a_status_w1c: assert property (@(posedge mclk) disable iff (reset)
		wr && hit(addr, pia_pkg::OFF_IRQ_STATUS) && !done
		|=> (irq_status & $past(wdata[pia_pkg::EV_W-1:0])) == '0)
		else $error("status bits not cleared by writing one");

	a_mask_write: assert property (@(posedge mclk) disable iff (reset)
		wr && hit(addr, pia_pkg::OFF_IRQ_MASK)
		|=> irq_mask == $past(wdata[pia_pkg::EV_W-1:0]))
		else $error("mask register did not take the written value");

	a_read_loaded: assert property (@(posedge mclk) disable iff (reset)
		done && !ctrl.write_not_read |=> data_rd == $past(frame_rd_data))
		else $error("read data not loaded as busy cleared");

	a_write_keeps_rd: assert property (@(posedge mclk) disable iff (reset)
		done && ctrl.write_not_read |=> $stable(data_rd))
		else $error("write access disturbed the returned data");

	a_data_readback: assert property (@(posedge mclk) disable iff (reset)
		rd && hit(addr, pia_pkg::OFF_DATA) |=>
		rdata == {16'h0000, $past(ctrl.write_not_read) ? $past(data_wr) : $past(data_rd)})
		else $error("data register read returned the wrong half");

	a_reserved_zero: assert property (@(posedge mclk) disable iff (reset)
		rd && hit(addr, pia_pkg::OFF_CTRL) |=> rdata[31:16] == 16'h0000
		&& rdata[5:2] == 4'h0)
		else $error("reserved control bits read nonzero");

	a_rdata_idle: assert property (@(posedge mclk) disable iff (reset)
		!rd |=> rdata == 32'h00000000)
		else $error("read data not zero outside its cycle");

	a_one_frame: assert property (@(posedge mclk) disable iff (reset)
		frames_open <= 1 && (busy || frames_open == 0))
		else $error("more than one frame per access");

	a_start_idle: assert property (@(posedge mclk) disable iff (reset)
		start |-> busy && frames_open == 0)
		else $error("frame launched while another was open");

	a_pins_idle: assert property (@(posedge mclk) disable iff (reset)
		!busy |-> mdio_oe_n && !mdc)
		else $error("management pins active with no access");

	a_data_width: assert property (@(posedge mclk) disable iff (reset)
		data_wr_hit |=> data_wr == $past(wdata[15:0]))
		else $error("data register did not take bits 15:0");

	a_data_hold: assert property (@(posedge mclk) disable iff (reset)
		!data_wr_hit |=> $stable(data_wr))
		else $error("data register changed without a write");

	c_write_done: cover property (@(posedge mclk) disable iff (reset)
		done && ctrl.write_not_read);
	c_read_done: cover property (@(posedge mclk) disable iff (reset)
		done && !ctrl.write_not_read);
	c_refused: cover property (@(posedge mclk) disable iff (reset)
		ctrl_wr && busy);
	c_irq: cover property (@(posedge mclk) disable iff (reset)
		$rose(irq));
	c_data_read: cover property (@(posedge mclk) disable iff (reset)
		rd && hit(addr, pia_pkg::OFF_DATA));
endmodule

/* logic/pia_frame.sv */
`timescale 1ns/1ps
module pia_frame
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic start,
	input wire pia_pkg::pia_req_t req,
	output logic done,
	output logic [15:0] rd_data,
	output logic mdc,
	output logic mdio_o,
	output logic mdio_oe_n,
	input wire logic mdio_i
);
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} pia_fstate_t;

	pia_fstate_t state;
	logic [63:0] shift;
	logic [5:0] bit_cnt;
	logic [5:0] div;
	logic is_read;
	logic half_end;
	logic [5:0] next_bit;

	function automatic logic [63:0] build_frame(input pia_pkg::pia_req_t r);
		logic rd;
		rd = !r.ctrl.write_not_read;
		build_frame = {pia_pkg::PREAMBLE, pia_pkg::START_CODE,
			rd ? pia_pkg::OP_READ : pia_pkg::OP_WRITE,
			r.ctrl.phy_addr, r.ctrl.reg_index,
			rd ? pia_pkg::TA_READ : pia_pkg::TA_WRITE,
			rd ? pia_pkg::READ_FILL : r.wr_data};
	endfunction

	assign half_end = (div == pia_pkg::MDC_HALF_CYC - 6'h01);
	assign next_bit = bit_cnt + 6'h01;

	// ==========================================
	// Clock divider and bit sequencer
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			state <= ST_IDLE;
			shift <= '0;
			bit_cnt <= '0;
			div <= '0;
			mdc <= 1'b0;
			mdio_o <= 1'b1;
			mdio_oe_n <= 1'b1;
			is_read <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					if (start)
					begin
						// One clause 22 frame per start
						shift <= build_frame(req);
						is_read <= !req.ctrl.write_not_read;
						bit_cnt <= '0;
						div <= '0;
						mdc <= 1'b0;
						mdio_o <= pia_pkg::PREAMBLE[31];
						mdio_oe_n <= 1'b0;
						state <= ST_RUN;
					end
				end
				ST_RUN:
				begin
					div <= half_end ? 6'h00 : div + 6'h01;
					if (half_end)
					begin
						mdc <= !mdc;
						if (mdc)
						begin
							if (bit_cnt == pia_pkg::FRAME_LAST)
							begin
								done <= 1'b1;
								mdio_oe_n <= 1'b1;
								mdio_o <= 1'b1;
								state <= ST_IDLE;
							end
							else
							begin
								bit_cnt <= next_bit;
								shift <= {shift[62:0], 1'b0};
								mdio_o <= shift[62];
								// Release the line from turnaround on reads
								mdio_oe_n <= is_read && (next_bit >= pia_pkg::TA_FIRST);
							end
						end
					end
				end
				default:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// Read data capture on rising MDC
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			rd_data <= pia_pkg::DATA_RESET;
		else if (state == ST_RUN && half_end && !mdc && is_read
			&& bit_cnt >= pia_pkg::DATA_FIRST)
			rd_data <= {rd_data[14:0], mdio_i};
	end

	// ==========================================
	// Checks
	a_idle_released: assert property (@(posedge mclk) disable iff (reset)
		state == ST_IDLE |-> mdio_oe_n && !mdc)
		else $error("mdio driven or mdc high while idle");

	a_start_drives: assert property (@(posedge mclk) disable iff (reset)
		state == ST_IDLE && start |=> (!mdio_oe_n && mdio_o && !mdc) [*8])
		else $error("frame did not begin with driven preamble");
endmodule

/* logic/pia_pkg.sv */
package pia_pkg;
	// ==========================================
	// Register map
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_DATA = 12'h0a4;
	localparam logic [11:0] OFF_CTRL = 12'h0a8;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h0ac;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h0b0;

	// ==========================================
	// Field positions
	localparam int PHY_HI = 15;
	localparam int PHY_LO = 11;
	localparam int IDX_HI = 10;
	localparam int IDX_LO = 6;
	localparam int WNR_BIT = 1;
	localparam int BUSY_BIT = 0;
	localparam int DATA_HI = 15;
	localparam int DATA_LO = 0;

	// ==========================================
	// Events
	localparam int EV_W = 2;
	localparam int EV_DONE = 0;
	localparam int EV_REFUSED = 1;
	localparam logic [1:0] EV_RESET = 2'h0;

	// ==========================================
	// Reset values
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [4:0] FIELD5_RESET = 5'h00;

	// ==========================================
	// Management frame layout
	localparam logic [5:0] FRAME_LAST = 6'h3f;
	localparam logic [5:0] TA_FIRST = 6'h2e;
	localparam logic [5:0] DATA_FIRST = 6'h30;
	localparam logic [31:0] PREAMBLE = 32'hffffffff;
	localparam logic [1:0] START_CODE = 2'h1;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] TA_WRITE = 2'h2;
	localparam logic [1:0] TA_READ = 2'h3;
	localparam logic [15:0] READ_FILL = 16'hffff;

	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int MDC_HALF_NS = 200;
	localparam logic [5:0] MDC_HALF_CYC =
		6'((MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ==========================================
	// Types
	typedef struct packed
	{
		logic [4:0] phy_addr;
		logic [4:0] reg_index;
		logic write_not_read;
	} pia_ctrl_t;

	typedef struct packed
	{
		pia_ctrl_t ctrl;
		logic [15:0] wr_data;
	} pia_req_t;
endpackage

/* test/pia_ctrl_bench.sv */
`timescale 1ns/1ps
module pia_ctrl_bench;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic irq, mdc, mdio_o, mdio_oe_n, mdio_i;
	logic [63:0] last_frame;
	int frames;
	int fails = 0;
	int compares = 0;

	always #2 mclk = ~mclk;

	pia_ctrl i_pia_ctrl (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq), .mdc(mdc), .mdio_o(mdio_o),
		.mdio_oe_n(mdio_oe_n), .mdio_i(mdio_i));
	pia_phy_model i_pia_phy_model (.mdc(mdc), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n),
		.mdio_i(mdio_i), .last_frame(last_frame), .frames(frames));

	// ==========================================
	// Bus and check tasks
	task automatic results;
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic write_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic read_reg(input logic [11:0] a, output logic [31:0] d);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic wait_idle;
		logic [31:0] d;
		for (int n = 0; n < 4000; n++)
		begin
			read_reg(pia_pkg::OFF_CTRL, d);
			if (d[0] === 1'b0)
				return;
		end
		fails++;
		results();
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset;
		logic [31:0] d;
		check("mdc idle", 64'h0, mdc);
		check("oe_n idle", 64'h1, mdio_oe_n);
		check("irq idle", 64'h0, irq);
		read_reg(pia_pkg::OFF_CTRL, d);
		check("ctrl reset", 64'h0, d);
		read_reg(pia_pkg::OFF_DATA, d);
		check("data reset", pia_pkg::DATA_RESET, d[15:0]);
		write_reg(12'h0f0, 32'hffffffff);
		read_reg(12'h0f0, d);
		check("unmapped", 64'h0, d);
		read_reg(pia_pkg::OFF_IRQ_MASK, d);
		check("mask reset", 64'h0, d);
	endtask

	task automatic t_write;
		logic [31:0] d;
		int f0;
		f0 = frames;
		write_reg(pia_pkg::OFF_IRQ_MASK, 32'h00000001);
		write_reg(pia_pkg::OFF_DATA, 32'hffff5aa5);
		write_reg(pia_pkg::OFF_CTRL, 32'hffffda7f);
		read_reg(pia_pkg::OFF_CTRL, d);
		check("ctrl busy", 64'h0000da43, d);
		wait_idle();
		read_reg(pia_pkg::OFF_CTRL, d);
		check("ctrl done", 64'h0000da42, d);
		check("write frames", f0 + 1, frames);
		check("write frame", {32'hffffffff, 2'h1, 2'h1, 5'h1b, 5'h09, 2'h2, 16'h5aa5},
			last_frame);
		read_reg(pia_pkg::OFF_DATA, d);
		check("data written", 64'h5aa5, d[15:0]);
		check("irq done", 64'h1, irq);
		write_reg(pia_pkg::OFF_IRQ_STATUS, 32'h00000001);
		read_reg(pia_pkg::OFF_IRQ_STATUS, d);
		check("status clear", 64'h0, d);
		check("irq clear", 64'h0, irq);
	endtask

	task automatic t_read;
		logic [31:0] d;
		write_reg(pia_pkg::OFF_IRQ_MASK, 32'h00000000);
		write_reg(pia_pkg::OFF_DATA, 32'h00000f0f);
		write_reg(pia_pkg::OFF_CTRL, 32'h00001240);
		wait_idle();
		check("read frame", {32'hffffffff, 2'h1, 2'h2, 5'h02, 5'h09},
			last_frame[63:18]);
		read_reg(pia_pkg::OFF_DATA, d);
		check("data read", 64'h5aa5, d[15:0]);
		check("irq masked", 64'h0, irq);
		write_reg(pia_pkg::OFF_IRQ_MASK, 32'h00000001);
		check("irq unmasked", 64'h1, irq);
		write_reg(pia_pkg::OFF_IRQ_STATUS, 32'h00000001);
		check("irq clear", 64'h0, irq);
	endtask

	task automatic t_busy;
		logic [31:0] d;
		int f0;
		f0 = frames;
		write_reg(pia_pkg::OFF_CTRL, 32'h00001a40);
		write_reg(pia_pkg::OFF_CTRL, 32'h0000f842);
		read_reg(pia_pkg::OFF_CTRL, d);
		check("ctrl kept", 64'h00001a41, d);
		read_reg(pia_pkg::OFF_IRQ_STATUS, d);
		check("refused flag", 64'h2, d);
		check("irq refused masked", 64'h0, irq);
		wait_idle();
		check("busy frames", f0 + 1, frames);
		check("busy phy", 64'h03, last_frame[27:23]);
		write_reg(pia_pkg::OFF_IRQ_STATUS, 32'h00000003);
		check("irq end", 64'h0, irq);
	endtask

	initial
	begin
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		t_reset();
		t_write();
		t_read();
		t_busy();
		results();
	end
endmodule

/* test/pia_phy_model.sv */
`timescale 1ns/1ps
module pia_phy_model
(
	input wire logic mdc,
	input wire logic mdio_o,
	input wire logic mdio_oe_n,
	output logic mdio_i,
	output logic [63:0] last_frame,
	output int frames
);
	logic [15:0] regs [0:31];
	logic [63:0] sr;
	logic [63:0] w;
	logic [1:0] op;
	logic [4:0] idx;
	logic drv;
	logic val;
	int cnt;

	// Design wins, then model, else pull-up
	assign mdio_i = !mdio_oe_n ? mdio_o : (drv ? val : 1'b1);

	initial
	begin
		for (int i = 0; i < 32; i++)
			regs[i] = 16'h0000;
		sr = 64'h0;
		last_frame = 64'h0;
		frames = 0;
		cnt = 0;
		drv = 1'b0;
		val = 1'b1;
		op = 2'h0;
		idx = 5'h00;
	end

	always @(negedge mdio_oe_n)
	begin
		cnt = 0;
	end

	// Shift in bits on mdc rise, one frame each 64 bits
	always @(posedge mdc)
	begin
		w = {sr[62:0], mdio_i};
		sr = w;
		cnt = cnt + 1;
		if (cnt == 36)
			op = w[1:0];
		if (cnt == 46)
			idx = w[4:0];
		if (cnt == 64)
		begin
			last_frame = w;
			frames = frames + 1;
			if (w[29:28] == 2'h1)
				regs[w[22:18]] = w[15:0];
		end
	end

	// Turnaround zero then data msb first on reads
	always @(negedge mdc)
	begin
		drv = mdio_oe_n && (op == 2'h2) && (cnt >= 47) && (cnt <= 63);
		val = (cnt >= 48 && cnt <= 63) ? regs[idx][63 - cnt] : 1'b0;
	end
endmodule
